// >>> core/tmfc_pkg.sv
// Constants, layouts and types of the transmitter mode and fail-safe control
package tmfc_pkg;

   // Serial register map
   localparam logic [6:0] ADDR_TXCMD   = 7'h00;
   localparam logic [6:0] ADDR_STAT    = 7'h01;
   localparam logic [6:0] CFG_BASE     = 7'h02;
   localparam int         CFG_N        = 8;
   localparam logic [2:0] IDX_MODE_CFG = 3'h2;   // mode_failsafe_config 0x04
   localparam logic [2:0] IDX_SLP_CFG  = 3'h3;   // modulation_sleep_config 0x05

   // Field positions
   localparam int REQ_BIT    = 7;   // standby / sleep request bits
   localparam int FAILSAFE_DISABLE_BIT_BIT  = 4;   // failsafe_disable_bit
   localparam int PAMODE_BIT = 0;   // amplifier-mode bit of transmit command
   localparam int STAT_LBL   = 5;
   localparam int STAT_LBU   = 4;
   localparam int STAT_BO    = 2;
   localparam int STAT_PAR   = 1;
   localparam int STAT_LCK   = 0;

   // Reset values
   localparam logic [7:0] MODE_CFG_RST = 8'h06;
   localparam logic [7:0] SLP_CFG_RST  = 8'h25;
   localparam logic [7:0] CFG_ZERO_RST = 8'h00;
   localparam logic [7:0] STAT_FIXED   = 8'hC0;

   // Serial framing: command byte then data byte, MSB first
   localparam logic [3:0] CMD_LAST_BIT = 4'h7;
   localparam logic [3:0] DAT_LAST_BIT = 4'hF;
   localparam int         RD_BIT       = 7;

   // Timing
   localparam int         TIMEOUT_DEF  = 65536;
   localparam logic [2:0] WAKE_PULSES  = 3'h3;
   localparam logic [1:0] SD_CYC       = 2'h2;

   typedef struct packed {
      logic lbl;
      logic lbu;
      logic bo;
      logic par;
      logic lck;
   } tmfc_flags_t;

   typedef enum logic [2:0] {
      ST_SLEEP, ST_SHUTDOWN, ST_STANDBY, ST_OSC, ST_SYN, ST_TX
   } tmfc_state_t;

endpackage

// >>> core/tmfc_top.sv
// Transmitter operating-mode sequencer with fail-safe status logic
//
// Operation
// - Sleep wakes on enable high plus three clocks
// - Sleep needs request bit then enable low
// - Sleep request bit clears on wake
// - Sleep shutdown takes two clock cycles
// - Sleep drops all config; host reprograms
// - Idle timeout with enable low enters standby
// - Standby needs request bit then enable low
// - Standby request bit clears itself
// - Standby keeps registers accessible and parity-checked
// - Transmit entered by command, left on enable fall
// - Amplifier-mode one holds transmit until timeout
// - Enable rise enters oscillator-start, synthesizer off
// - Oscillator-start left by request, command or timeout
// - Synthesizer-start precedes transmit, amplifier off
// - Per-register parity, checked continuously
// - Brownout resets internally and sets flag
// - Lock loss in transmit sets flag
// - Error flags latch until status read
// - Fail-safe flags block amplifier unless disabled
// - Fail-safe disable bit resets to zero
// - Low battery flags and threshold switch
// - Low battery flags clear at transmit start
// - Status bit positions five, four, two, one, zero
`timescale 1ns/1ps
module tmfc_top
   import tmfc_pkg::*;
#(
   parameter int TIMEOUT_CYC = TIMEOUT_DEF
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        en,
   input  wire logic        sck,
   input  wire logic        sdio_i,
   output logic             sdio_o,
   output logic             sdio_oe,
   input  wire logic        bod_trip,
   input  wire logic        pll_lock,
   input  wire logic        batt_low,
   output tmfc_state_t      mode,
   output logic             osc_en,
   output logic             pll_en,
   output logic             pa_en,
   output logic             batt_thr_low
);

   localparam int TMO_W = $clog2(TIMEOUT_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   localparam int NSYNC = 6;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;
   logic             en_d_ff;
   logic             sck_d_ff;
   logic             en_s;
   logic             sck_s;
   logic             sdi_s;
   logic             bod_s;
   logic             lock_s;
   logic             batt_s;

   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (rst) begin
               meta_ff[g] <= 1'b0;
               sync_ff[g] <= 1'b0;
            end else begin
               meta_ff[g] <= (g == 0) ? en : (g == 1) ? sck :
                             (g == 2) ? sdio_i : (g == 3) ? bod_trip :
                             (g == 4) ? pll_lock : batt_low;
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign en_s   = sync_ff[0];
   assign sck_s  = sync_ff[1];
   assign sdi_s  = sync_ff[2];
   assign bod_s  = sync_ff[3];
   assign lock_s = sync_ff[4];
   assign batt_s = sync_ff[5];

   always_ff @(posedge mclk) begin
      if (rst) begin
         en_d_ff  <= 1'b0;
         sck_d_ff <= 1'b0;
      end else begin
         en_d_ff  <= en_s;
         sck_d_ff <= sck_s;
      end
   end

   logic en_rise;
   logic en_fall;
   logic sck_rise;
   logic sck_fall;
   logic int_rst;
   assign en_rise  = en_s & ~en_d_ff;
   assign en_fall  = ~en_s & en_d_ff;
   assign sck_rise = sck_s & ~sck_d_ff;
   assign sck_fall = ~sck_s & sck_d_ff;
   // Brownout acts as an internal reset of everything but the flags, the battery threshold, the serial port, the pin synchronisers and the wake and shutdown counters
   assign int_rst  = rst | bod_s;

   ////////////////////////////////////////////////////////////////////////////
   // Serial port: stays alive in every mode, framed by enable

   logic [3:0]  bitcnt_ff;
   logic [7:0]  sh_ff;
   logic        cmd_rd_ff;
   logic [6:0]  cmd_addr_ff;
   logic [7:0]  txsh_ff;
   logic [7:0]  nxt_sh;
   logic        cmd_done;
   logic        wr_done;
   logic        stat_clr;
   logic [7:0]  rd_val;

   assign nxt_sh   = {sh_ff[6:0], sdi_s};
   assign cmd_done = en_s & sck_rise & (bitcnt_ff == CMD_LAST_BIT);
   assign wr_done  = en_s & sck_rise & (bitcnt_ff == DAT_LAST_BIT) & ~cmd_rd_ff;
   assign stat_clr = cmd_done & nxt_sh[RD_BIT] & (nxt_sh[6:0] == ADDR_STAT);

   function automatic logic cfg_hit(input logic [6:0] a);
      return (a >= CFG_BASE) && (a < CFG_BASE + 7'(CFG_N));
   endfunction

   function automatic logic [2:0] cfg_idx(input logic [6:0] a);
      logic [6:0] d;
      d = a - CFG_BASE;
      return d[2:0];
   endfunction

   function automatic logic [7:0] cfg_rst(input int i);
      return (i == int'(IDX_MODE_CFG)) ? MODE_CFG_RST :
             (i == int'(IDX_SLP_CFG))  ? SLP_CFG_RST  : CFG_ZERO_RST;
   endfunction

   always_ff @(posedge mclk) begin
      if (rst || !en_s) begin
         bitcnt_ff   <= 4'h0;
         sh_ff       <= 8'h00;
         cmd_rd_ff   <= 1'b0;
         cmd_addr_ff <= 7'h00;
      end else if (sck_rise) begin
         bitcnt_ff <= bitcnt_ff + 4'h1;
         sh_ff     <= nxt_sh;
         if (bitcnt_ff == CMD_LAST_BIT) begin
            cmd_rd_ff   <= nxt_sh[RD_BIT];
            cmd_addr_ff <= nxt_sh[6:0];
         end
      end
   end

   // Read data leaves on falling clock edges so the host samples on rising
   always_ff @(posedge mclk) begin
      if (rst || !en_s) begin
         txsh_ff <= 8'h00;
         sdio_o  <= 1'b0;
         sdio_oe <= 1'b0;
      end else if (cmd_done && nxt_sh[RD_BIT]) begin
         txsh_ff <= rd_val;
      end else if (sck_fall && cmd_rd_ff && bitcnt_ff > CMD_LAST_BIT) begin
         sdio_o  <= txsh_ff[7];
         sdio_oe <= 1'b1;
         txsh_ff <= {txsh_ff[6:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers with parity

   logic [7:0]       cfg_ff [CFG_N];
   logic [CFG_N-1:0] par_ff;
   logic [CFG_N-1:0] par_bad;
   logic             stby_pend_ff;
   logic             pamode_ff;
   logic             failsafe_disable_bit;
   logic             slp_req;
   logic             tx_cmd;
   tmfc_state_t      state_ff;
   tmfc_state_t      nxt_state;

   assign failsafe_disable_bit   = cfg_ff[IDX_MODE_CFG][FAILSAFE_DISABLE_BIT_BIT];
   assign slp_req = cfg_ff[IDX_SLP_CFG][REQ_BIT];
   assign tx_cmd  = wr_done & (cmd_addr_ff == ADDR_TXCMD) & (state_ff == ST_OSC);

   always_ff @(posedge mclk) begin
      // Sleep removes supply from the register bank, so contents revert
      if (int_rst || state_ff == ST_SLEEP) begin
         for (int i = 0; i < CFG_N; i++) begin
            cfg_ff[i] <= cfg_rst(i);
            par_ff[i] <= ^cfg_rst(i);
         end
      end else if (wr_done && cfg_hit(cmd_addr_ff)) begin
         cfg_ff[cfg_idx(cmd_addr_ff)] <= nxt_sh;
         par_ff[cfg_idx(cmd_addr_ff)] <= ^nxt_sh;
         if (cfg_idx(cmd_addr_ff) == IDX_MODE_CFG) begin
            cfg_ff[IDX_MODE_CFG][REQ_BIT] <= 1'b0;
            par_ff[IDX_MODE_CFG] <= ^{1'b0, nxt_sh[6:0]};
         end
      end
   end

   // Standby request is kept as a hidden one-shot until standby is entered
   always_ff @(posedge mclk) begin
      if (int_rst || state_ff == ST_SLEEP || nxt_state == ST_STANDBY) begin
         stby_pend_ff <= 1'b0;
      end else if (wr_done && cmd_addr_ff == CFG_BASE + 7'(IDX_MODE_CFG)
                   && nxt_sh[REQ_BIT]) begin
         stby_pend_ff <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (int_rst) begin
         pamode_ff <= 1'b0;
      end else if (tx_cmd) begin
         pamode_ff <= nxt_sh[PAMODE_BIT];
      end
   end

   generate
      for (g = 0; g < CFG_N; g++) begin : g_par
         assign par_bad[g] = (^cfg_ff[g]) != par_ff[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Status flags (survive brownout; error flags cleared only by a status read, battery flags at transmit start)

   tmfc_flags_t flags_ff;
   tmfc_flags_t flag_set;
   logic        fs_block;
   logic        tx_start;

   assign tx_start = (state_ff == ST_SYN) && (nxt_state == ST_TX);
   assign fs_block = ~failsafe_disable_bit & (flags_ff.bo | flags_ff.par | flags_ff.lck);

   always_comb begin
      flag_set.bo  = bod_s;
      flag_set.par = |par_bad;
      flag_set.lck = (state_ff == ST_TX) & ~lock_s;
      flag_set.lbu = batt_s & ~batt_thr_low;
      flag_set.lbl = batt_s & batt_thr_low;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_ff <= '{lbl: 1'b0, lbu: 1'b0, bo: 1'b1, par: 1'b0, lck: 1'b0};
      end else begin
         // A new event in the clearing cycle stays set
         flags_ff.bo  <= (flags_ff.bo  & ~stat_clr) | flag_set.bo;
         flags_ff.par <= (flags_ff.par & ~stat_clr) | flag_set.par;
         flags_ff.lck <= (flags_ff.lck & ~stat_clr) | flag_set.lck;
         flags_ff.lbu <= (flags_ff.lbu & ~tx_start) | flag_set.lbu;
         flags_ff.lbl <= (flags_ff.lbl & ~tx_start) | flag_set.lbl;
      end
   end

   // A drop seen at the upper threshold in the transmit-start cycle still selects the lower threshold
   always_ff @(posedge mclk) begin
      if (rst) begin
         batt_thr_low <= 1'b0;
      end else if (flag_set.lbu) begin
         batt_thr_low <= 1'b1;
      end else if (tx_start) begin
         batt_thr_low <= 1'b0;
      end
   end

   always_comb begin
      rd_val = 8'h00;
      if (nxt_sh[6:0] == ADDR_STAT) begin
         rd_val = STAT_FIXED;
         rd_val[STAT_LBL] = flags_ff.lbl;
         rd_val[STAT_LBU] = flags_ff.lbu;
         rd_val[STAT_BO]  = flags_ff.bo;
         rd_val[STAT_PAR] = flags_ff.par;
         rd_val[STAT_LCK] = flags_ff.lck;
      end else if (cfg_hit(nxt_sh[6:0])) begin
         rd_val = cfg_ff[cfg_idx(nxt_sh[6:0])];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counters: wake pulses, shutdown latency, idle and hold timeout

   logic [2:0]       wk_ff;
   logic [1:0]       sd_ff;
   logic [TMO_W-1:0] tmo_ff;
   logic             hold_ff;
   logic             tmo_done;
   logic             tmo_run;

   assign tmo_done = tmo_ff == TMO_W'(TIMEOUT_CYC - 1);
   assign tmo_run  = (state_ff == ST_OSC && !en_s && !sck_rise)
                     || (state_ff == ST_TX && hold_ff);

   always_ff @(posedge mclk) begin
      if (rst || state_ff != ST_SLEEP || !en_s) begin
         wk_ff <= 3'h0;
      end else if (sck_rise && wk_ff < WAKE_PULSES) begin
         wk_ff <= wk_ff + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || state_ff != ST_SHUTDOWN) begin
         sd_ff <= 2'h0;
      end else begin
         sd_ff <= sd_ff + 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (int_rst || !tmo_run || nxt_state != state_ff) begin
         tmo_ff <= '0;
      end else begin
         tmo_ff <= tmo_ff + TMO_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (int_rst || state_ff != ST_TX) begin
         hold_ff <= 1'b0;
      end else if (en_fall && pamode_ff) begin
         hold_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencer

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_SLEEP: begin
            if (en_s && wk_ff >= WAKE_PULSES) nxt_state = ST_OSC;
         end
         ST_SHUTDOWN: begin
            if (sd_ff == SD_CYC - 2'h1) nxt_state = ST_SLEEP;
         end
         ST_STANDBY: begin
            if (en_rise) nxt_state = ST_OSC;
         end
         ST_OSC: begin
            if (en_fall && slp_req) nxt_state = ST_SHUTDOWN;
            else if (en_fall && stby_pend_ff) nxt_state = ST_STANDBY;
            else if (tx_cmd && !fs_block) nxt_state = ST_SYN;
            else if (tmo_done) nxt_state = ST_STANDBY;
         end
         ST_SYN: begin
            if (fs_block || !en_s) nxt_state = ST_OSC;
            else if (lock_s) nxt_state = ST_TX;
         end
         ST_TX: begin
            if (fs_block) nxt_state = ST_OSC;
            else if (en_fall && !pamode_ff) nxt_state = ST_OSC;
            else if (hold_ff && tmo_done) nxt_state = ST_OSC;
         end
         default: nxt_state = ST_OSC;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (int_rst) begin
         state_ff <= ST_OSC;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (int_rst) begin
         mode   <= ST_OSC;
         osc_en <= 1'b1;
         pll_en <= 1'b0;
         pa_en  <= 1'b0;
      end else begin
         mode   <= nxt_state;
         osc_en <= nxt_state != ST_SLEEP && nxt_state != ST_STANDBY;
         pll_en <= nxt_state == ST_SYN || nxt_state == ST_TX;
         pa_en  <= nxt_state == ST_TX && !fs_block;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_sleep_hold;
      state_ff == ST_SLEEP && !en_s |=> state_ff == ST_SLEEP;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("sleep left without enable");

   property p_wake_clears;
      state_ff == ST_SLEEP ##1 state_ff == ST_OSC |-> !slp_req;
   endproperty
   a_wake_clears: assert property (p_wake_clears)
      else $error("sleep request not cleared on wake");

   property p_shutdown;
      $rose(state_ff == ST_SHUTDOWN) |-> state_ff == ST_SHUTDOWN [*2]
         ##1 state_ff == ST_SLEEP;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown latency wrong");

   property p_idle_stby;
      state_ff == ST_OSC && tmo_done && tmo_run && !en_fall && !tx_cmd
         && !bod_s |=> state_ff == ST_STANDBY;
   endproperty
   a_idle_stby: assert property (p_idle_stby)
      else $error("idle timeout did not enter standby");

   property p_stby_bit;
      !cfg_ff[IDX_MODE_CFG][REQ_BIT];
   endproperty
   a_stby_bit: assert property (p_stby_bit)
      else $error("standby request bit stored");

   property p_pa_off_syn;
      state_ff == ST_SYN |-> !pa_en;
   endproperty
   a_pa_off_syn: assert property (p_pa_off_syn)
      else $error("amplifier on in synthesizer start");

   property p_flag_latch;
      flags_ff.par && !stat_clr |=> flags_ff.par;
   endproperty
   a_flag_latch: assert property (p_flag_latch)
      else $error("parity flag lost without read");

   property p_set_wins;
      stat_clr && bod_s |=> flags_ff.bo;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("brownout event lost under read");

   property p_failsafe;
      fs_block |=> !pa_en;
   endproperty
   a_failsafe: assert property (p_failsafe)
      else $error("amplifier on under fail-safe");

   property p_failsafe_disable_bit_rst;
      $fell(rst) |-> !failsafe_disable_bit;
   endproperty
   a_failsafe_disable_bit_rst: assert property (@(posedge mclk) p_failsafe_disable_bit_rst)
      else $error("fail-safe disable set after reset");

   property p_lbu_thr;
      flag_set.lbu |=> batt_thr_low && flags_ff.lbu;
   endproperty
   a_lbu_thr: assert property (p_lbu_thr)
      else $error("threshold not switched");

   c_sleep: cover property (state_ff == ST_SHUTDOWN ##2 state_ff == ST_SLEEP);
   c_tx: cover property (state_ff == ST_SYN ##1 state_ff == ST_TX);
   c_hold: cover property (hold_ff && tmo_done);
   c_rdclr: cover property (stat_clr && flags_ff.bo);

endmodule

// >>> tb/tmfc_host.sv
// Host controller model: drives chip-enable and the serial port
`timescale 1ns/1ps
module tmfc_host (
   input  wire logic       mclk,
   input  wire logic       sdio_o,
   input  wire logic       sdio_oe,
   output logic            en,
   output logic            sck,
   output logic            sdio_i,
   output logic [7:0]      rd_byte,
   output logic            rd_vld
);
   logic drv_on;
   logic drv_v;

   // A released line shows the inverse of the last bit, never a held value
   assign sdio_i = sdio_oe ? sdio_o : (drv_on ? drv_v : ~drv_v);

   initial begin
      en = 1'b0;
      sck = 1'b0;
      drv_on = 1'b1;
      drv_v = 1'b0;
      rd_byte = 8'h00;
      rd_vld = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   ////////////////////////////////////////
   // Six-cycle phases keep sck well above the sampling minimum
   task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
                        input int nb, input bit keep);
      logic [15:0] sh;
      logic [7:0]  rb;
      sh = {cmd, dat};
      rb = 8'h00;
      step(4);
      en = 1'b1;
      for (int i = 0; i < nb; i++) begin
         if (cmd[7] && i >= 8)
            drv_on = 1'b0;
         else
            drv_v = sh[15 - i];
         step(6);
         if (i >= 8)
            rb = {rb[6:0], sdio_i};
         sck = 1'b1;
         step(6);
         sck = 1'b0;
      end
      step(6);
      drv_on = 1'b1;
      if (!keep)
         en = 1'b0;
      if (cmd[7] && nb == 16) begin
         rd_byte = rb;
         rd_vld = 1'b1;
         step(1);
         rd_vld = 1'b0;
      end
   endtask

   task automatic drop_en();
      step(1);
      en = 1'b0;
   endtask
endmodule

// >>> tb/tmfc_top_bench.sv
// Self-checking bench of the mode sequencer and fail-safe status
`timescale 1ns/1ps
module tmfc_top_bench
   import tmfc_pkg::*;
();
   localparam int TO = 64;
   logic        mclk, rst, en, sck, sdio_i, sdio_o, sdio_oe;
   logic        bod_trip, pll_lock, batt_low;
   logic        osc_en, pll_en, pa_en, batt_thr_low, rd_vld;
   tmfc_state_t mode;
   logic [7:0]  rd_byte, d, cnt;
   logic [15:0] r;
   logic [7:0]  expq[$];
   logic [15:0] seed = 16'hC5AB;
   int          miscompares = 0;
   int          cmp_count = 0;

   tmfc_top #(.TIMEOUT_CYC(TO)) tmfc_top_i (
      .mclk(mclk), .rst(rst), .en(en), .sck(sck), .sdio_i(sdio_i),
      .sdio_o(sdio_o), .sdio_oe(sdio_oe), .bod_trip(bod_trip),
      .pll_lock(pll_lock), .batt_low(batt_low), .mode(mode),
      .osc_en(osc_en), .pll_en(pll_en), .pa_en(pa_en),
      .batt_thr_low(batt_thr_low));

   tmfc_host tmfc_host_i (
      .mclk(mclk), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .en(en),
      .sck(sck), .sdio_i(sdio_i), .rd_byte(rd_byte), .rd_vld(rd_vld));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("Checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [15:0] xs();
      seed ^= seed << 7;
      seed ^= seed >> 9;
      seed ^= seed << 8;
      return seed;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask

   // Reads only note the expectation; the monitor compares later
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      expq.push_back(e);
      tmfc_host_i.frame({1'b1, a}, 8'h00, 16, 1'b0);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      tmfc_host_i.frame({1'b0, a}, v, 16, 1'b0);
   endtask

   task automatic chk_out(input tmfc_state_t m, input logic o,
                          input logic p, input logic a);
      check("mode", {5'h00, mode}, {5'h00, m});
      check("osc_en", {7'h00, osc_en}, {7'h00, o});
      check("pll_en", {7'h00, pll_en}, {7'h00, p});
      check("pa_en", {7'h00, pa_en}, {7'h00, a});
   endtask

   // Leaves chip-enable high: a low enable would abort the start
   task automatic tx(input logic pam);
      pll_lock = 1'b0;
      tmfc_host_i.frame({1'b0, ADDR_TXCMD}, {7'h00, pam}, 16, 1'b1);
      cyc(10);
      chk_out(ST_SYN, 1'b1, 1'b1, 1'b0);
      pll_lock = 1'b1;
      cyc(8);
      chk_out(ST_TX, 1'b1, 1'b1, 1'b1);
   endtask

   always @(posedge mclk) begin
      if (rd_vld === 1'b1) begin
         if (expq.size() == 0)
            check("read queue", 8'h00, 8'hFF);
         else
            check("read data", rd_byte, expq.pop_front());
      end
   end

   initial begin
      #(50 * 30000);
      miscompares++;
      test_done();
   end

   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      bod_trip = 1'b0;
      pll_lock = 1'b0;
      batt_low = 1'b0;
      cnt = 8'h00;
      cyc(5);
      rst = 1'b0;
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      rd(ADDR_STAT, 8'hC4);
      rd(ADDR_STAT, 8'hC0);
      rd(7'h04, MODE_CFG_RST);
      rd(7'h05, SLP_CFG_RST);
      rd(7'h7F, 8'h00);
      for (int a = 2; a < 10; a++) begin
         if (a != 4 && a != 5) begin
            r = xs();
            d = r[7:0];
            wr(7'(a), d);
            rd(7'(a), d);
         end
      end
      rd(ADDR_STAT, 8'hC0);
      tx(1'b0);
      tmfc_host_i.drop_en();
      cyc(8);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      tx(1'b1);
      tmfc_host_i.drop_en();
      cyc(TO / 2);
      chk_out(ST_TX, 1'b1, 1'b1, 1'b1);
      cyc(TO);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      // Lock lost mid-transmission
      tx(1'b0);
      pll_lock = 1'b0;
      cyc(8);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      tmfc_host_i.drop_en();
      rd(ADDR_STAT, 8'hC1);
      rd(ADDR_STAT, 8'hC0);
      batt_low = 1'b1;
      rd(ADDR_STAT, 8'hF0);
      check("thr", {7'h00, batt_thr_low}, 8'h01);
      batt_low = 1'b0;
      rd(ADDR_STAT, 8'hF0);
      tx(1'b0);
      check("thr", {7'h00, batt_thr_low}, 8'h00);
      tmfc_host_i.drop_en();
      rd(ADDR_STAT, 8'hC0);
      pll_lock = 1'b0;
      // Brownout wipes config and blocks the next start
      wr(7'h02, 8'h3C);
      bod_trip = 1'b1;
      cyc(5);
      bod_trip = 1'b0;
      cyc(8);
      rd(7'h02, 8'h00);
      tmfc_host_i.frame({1'b0, ADDR_TXCMD}, 8'h00, 16, 1'b1);
      cyc(10);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      tmfc_host_i.drop_en();
      rd(ADDR_STAT, 8'hC4);
      wr(7'h04, 8'h86);
      cyc(10);
      chk_out(ST_STANDBY, 1'b0, 1'b0, 1'b0);
      rd(7'h04, 8'h06);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      cyc(40);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      cyc(40);
      chk_out(ST_STANDBY, 1'b0, 1'b0, 1'b0);
      wr(7'h02, 8'h5A);
      wr(7'h05, 8'hA5);
      for (int i = 0; i < 14; i++) begin
         cyc(1);
         if (mode === ST_SHUTDOWN)
            cnt = cnt + 8'h01;
      end
      check("shutdown cycles", cnt, 8'h02);
      chk_out(ST_SLEEP, 1'b0, 1'b0, 1'b0);
      // Two pulses are one short of a wake-up
      tmfc_host_i.frame(8'h7F, 8'h00, 2, 1'b0);
      cyc(10);
      chk_out(ST_SLEEP, 1'b0, 1'b0, 1'b0);
      tmfc_host_i.frame(8'h7F, 8'h00, 3, 1'b0);
      cyc(10);
      chk_out(ST_OSC, 1'b1, 1'b0, 1'b0);
      rd(7'h05, SLP_CFG_RST);
      rd(7'h02, 8'h00);
      cyc(4);
      test_done();
   end
endmodule
